// ---- fanr_pkg.sv ----
// fanr_pkg: constants, register map and fault tables for the fault annunciator
package fanr_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int FLASH_HALF_MS = 500;
    localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_MHZ * 1000;
    localparam int FLASH_CNT_W = 27;

    // ------------------------------------------------------------------
    // fault table layout
    // ------------------------------------------------------------------
    localparam int N_FAULT = 29;
    localparam int N_COND_PIN = 28;
    localparam int IDX_IDLE = 0;
    localparam int IDX_CUST = 25;
    localparam int N_CUST = 4;
    localparam int SYNC_W = 35;
    localparam logic [28:0] WARN_MASK = 29'h0000_0FFF;
    localparam logic [28:0] SHUT_MASK = 29'h01FF_F000;
    localparam logic [28:0] ESTOP_BIT = 29'h0000_1000;
    localparam logic [28:0] IND_RST = 29'h0000_0000;
    // code and first display line per fault index, sixteen characters each
    localparam logic [9:0] CODE_TAB [N_FAULT] = '{10'd101, 10'd200, 10'd213, 10'd230, 10'd231, 10'd232, 10'd240,
        10'd241, 10'd251, 10'd252, 10'd320, 10'd330, 10'd102, 10'd212, 10'd215, 10'd220, 10'd221, 10'd222, 10'd223,
        10'd250, 10'd301, 10'd303, 10'd313, 10'd321, 10'd322, 10'd260, 10'd261, 10'd262, 10'd263};
    localparam logic [127:0] MSG_TAB [N_FAULT] = '{"IDLE MODE       ", "LOW OIL PRESSURE", "COOLANT SENDER  ",
        "LOW DC VOLTAGE  ", "HIGH DC VOLTAGE ", "WEAK BATTERY    ", "LOW FUEL - DAY  ", "LOW FUEL        ",
        "EEPROM ERROR    ", "EEPROM ERROR    ", "OVERCURRENT     ", "OVERLOAD        ", "EMERGENCY STOP  ",
        "HIGH COOLANT TMP", "LOW COOLANT LVL ", "MAG PICKUP      ", "FAIL TO CRANK   ", "OVERCRANK       ",
        "OVERSPEED       ", "EEPROM ERROR    ", "HIGH AC VOLTAGE ", "LOW AC VOLTAGE  ", "UNDER FREQUENCY ",
        "OVERCURRENT     ", "SHORT CIRCUIT   ", "CUSTOMER FAULT 1", "GROUND FAULT    ", "RUPTURE BASIN   ",
        "HIGH GEN TEMP   "};

    // ------------------------------------------------------------------
    // mode selector encoding
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FANR_MODE_OFF = 2'h0,
        FANR_MODE_RUN = 2'h1,
        FANR_MODE_AUTO = 2'h2
    } fanr_mode_t;

    // remote reset cycle tracker, gray along idle -> held -> done
    typedef enum logic [1:0] {
        FANR_RR_IDLE = 2'h0,
        FANR_RR_HELD = 2'h1,
        FANR_RR_DONE = 2'h3
    } fanr_rr_t;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_IND = 8'h04;
    localparam logic [7:0] ADDR_CUST = 8'h08;
    localparam logic [7:0] ADDR_ISTAT = 8'h0C;
    localparam logic [7:0] ADDR_ICLR = 8'h10;
    localparam logic [7:0] ADDR_IEN = 8'h14;
    localparam logic [7:0] ADDR_DCODE = 8'h18;
    localparam logic [3:0] CUST_RST = 4'h0;
    localparam logic [2:0] IEN_RST = 3'h0;
    localparam int N_EV = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- fanr_sync.sv ----
// fanr_sync: three-stage input synchroniser with second/third stage agreement
`timescale 1ns/1ps
module fanr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    // a bit only moves once two settled stages agree, filtering one-cycle glitches
    assign nxt_q = (s2_ff & s3_ff) | (q_ff & (s2_ff | s3_ff));
    assign q = q_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            q_ff <= '0;
        end else if (ce) begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff <= nxt_q;
        end
    end
endmodule

// ---- fanr_core.sv ----
// fanr_core: fault annunciation, latching, reset and standby gating
// How it works
// [R1] yellow lamp lit while any warning is present or still unreset
// [R2] red lamp lit whenever a shutdown condition is present
// [R3] shutdown faults latch until a valid reset sequence clears them
// [R4] active shutdown stops the engine and closes breaker-trip contact
// [R5] any active fault shows its message on the display; only the highest-priority active fault is shown
// [R6] non-automatic lamp flashes continuously while selector is Off
// [R7] panel reset press clears cleared warnings, engine may keep running
// [R8] in Auto a completed remote reset cycle clears cleared warnings
// [R9] panel reset clears shutdowns only in Off with condition gone
// [R10] in Auto remote reset cycle clears shutdowns if remote start inactive
// [R11] emergency stop 102 clears only from the panel reset
// [R12] standby refused while any fault remains unreset
// [R13] messages are two lines of sixteen characters
// [R14] codes 101..330 listed as warnings light yellow, never stop engine
// [R15] codes 102..322 listed as shutdowns latch and light red
// [R16] codes 260 to 263 each configurable as warning or shutdown
// [R17] idle input grounded in Run raises warning 101, release clears it
// [R18] remote reset is synced assert-release; panel press edge-detected once
`timescale 1ns/1ps
module fanr_core
    import fanr_pkg::*;
#(
    parameter int FLASH_HALF = FLASH_HALF_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [N_COND_PIN-1:0] FAULT_COND,
    input wire logic IDLE_IN,
    input wire logic PANEL_RESET,
    input wire logic REMOTE_RESET,
    input wire logic REMOTE_START,
    input wire logic [1:0] MODE_SEL,
    input wire logic STANDBY_REQ,
    output logic WARN_LAMP,
    output logic SHUT_LAMP,
    output logic NONAUTO_LAMP,
    output logic ENGINE_STOP,
    output logic BREAKER_TRIP,
    output logic STANDBY,
    output logic [127:0] DISP_LINE1,
    output logic [127:0] DISP_LINE2,
    output logic IRQ,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    // ------------------------------------------------------------------
    // fault tables
    // ------------------------------------------------------------------
    function automatic logic [23:0] dec3(input logic [9:0] c);
        logic [3:0] h;
        logic [3:0] t;
        logic [3:0] u;
        h = 4'(c / 10'd100);
        t = 4'((c / 10'd10) % 10'd10);
        u = 4'(c % 10'd10);
        return {4'h3, h, 4'h3, t, 4'h3, u};
    endfunction

    // lowest set index wins; shutdowns are searched before warnings
    function automatic logic [4:0] first_idx(input logic [N_FAULT-1:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int k = N_FAULT - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = 5'(k);
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0] sync_q;
    logic [N_COND_PIN-1:0] cond_pin;
    logic idle_s, panel_s, rreset_s, rstart_s, sreq_s;
    logic [1:0] mode_s;

    fanr_sync #(.W(SYNC_W)) u_sync (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ce(CE),
        .d({STANDBY_REQ, MODE_SEL, REMOTE_START, REMOTE_RESET, PANEL_RESET, IDLE_IN, FAULT_COND}),
        .q(sync_q)
    );

    assign cond_pin = sync_q[N_COND_PIN-1:0];
    assign idle_s = sync_q[28];
    assign panel_s = sync_q[29];
    assign rreset_s = sync_q[30];
    assign rstart_s = sync_q[31];
    assign mode_s = sync_q[33:32];
    assign sreq_s = sync_q[34];

    // ------------------------------------------------------------------
    // reset events
    // ------------------------------------------------------------------
    logic panel_prev_ff, panel_press, rr_cycle, mode_off, mode_run, mode_auto;
    fanr_rr_t rr_ff, nxt_rr;

    assign panel_press = panel_s & ~panel_prev_ff;  // [R18]
    assign rr_cycle = (rr_ff == FANR_RR_DONE);
    assign mode_off = (mode_s == FANR_MODE_OFF);
    assign mode_run = (mode_s == FANR_MODE_RUN);
    assign mode_auto = (mode_s == FANR_MODE_AUTO);

    // cycle completes on release after an assert [R18]
    always_comb begin
        case (rr_ff)
            FANR_RR_IDLE: nxt_rr = rreset_s ? FANR_RR_HELD : FANR_RR_IDLE;
            FANR_RR_HELD: nxt_rr = rreset_s ? FANR_RR_HELD : FANR_RR_DONE;
            FANR_RR_DONE: nxt_rr = rreset_s ? FANR_RR_HELD : FANR_RR_IDLE;
            default: nxt_rr = FANR_RR_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // fault latching and clearing
    // ------------------------------------------------------------------
    logic [N_FAULT-1:0] ind_ff, nxt_ind, cond, shut_cls, warn_cls, clr_vec, shut_clr;
    logic [N_CUST-1:0] cust_ff;
    logic clr_warn, clr_shut_panel, clr_shut_remote;

    assign cond = {cond_pin, idle_s & mode_run};  // [R17]
    assign shut_cls = SHUT_MASK | (N_FAULT'(cust_ff) << IDX_CUST);  // [R15] [R16]
    assign warn_cls = ~shut_cls;  // [R14]
    assign clr_warn = panel_press | (rr_cycle & mode_auto);  // [R7] [R8]
    assign clr_shut_panel = panel_press & mode_off;  // [R9]
    assign clr_shut_remote = rr_cycle & mode_auto & ~rstart_s;  // [R10]
    assign shut_clr = {N_FAULT{clr_shut_panel}} | ({N_FAULT{clr_shut_remote}} & ~ESTOP_BIT);  // [R11]
    assign clr_vec = (warn_cls & {N_FAULT{clr_warn}}) | (shut_cls & shut_clr);

    // present condition always sets; clear only acts where condition is gone [R3]
    always_comb begin
        nxt_ind = cond | (ind_ff & ~(clr_vec & ~cond));
        nxt_ind[IDX_IDLE] = cond[IDX_IDLE];  // [R17]
    end

    // ------------------------------------------------------------------
    // lamps, outputs and display selection
    // ------------------------------------------------------------------
    logic [N_FAULT-1:0] shut_act, warn_act;
    logic any_shut, any_warn, flash_ff, flash_wrap;
    logic [4:0] sel_idx;
    logic [9:0] sel_code;
    logic [127:0] nxt_line1, nxt_line2;
    logic [FLASH_CNT_W-1:0] flash_cnt_ff;

    assign shut_act = nxt_ind & shut_cls;
    assign warn_act = nxt_ind & warn_cls;
    assign any_shut = |shut_act;
    assign any_warn = |warn_act;
    assign sel_idx = any_shut ? first_idx(shut_act) : first_idx(warn_act);
    assign sel_code = (any_shut | any_warn) ? CODE_TAB[sel_idx] : 10'h000;
    assign nxt_line1 = (any_shut | any_warn) ? MSG_TAB[sel_idx] : "NO ACTIVE FAULT ";  // [R5]
    assign nxt_line2 = any_shut ? {dec3(sel_code), " - SHUTDOWN  "} :
                       any_warn ? {dec3(sel_code), " - WARNING   "} : "                ";  // [R13]
    assign flash_wrap = (flash_cnt_ff == FLASH_CNT_W'(FLASH_HALF - 1));

    logic warn_lamp_ff, shut_lamp_ff, nonauto_ff, stop_ff, trip_ff, standby_ff;
    logic [127:0] line1_ff, line2_ff;
    logic [9:0] code_ff;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            panel_prev_ff <= 1'b0;
            rr_ff <= FANR_RR_IDLE;
            ind_ff <= IND_RST;
        end else if (CE) begin
            panel_prev_ff <= panel_s;
            rr_ff <= nxt_rr;
            ind_ff <= nxt_ind;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            flash_cnt_ff <= '0;
            flash_ff <= 1'b0;
        end else if (CE) begin
            // free-running so the blink phase stays steady across mode changes
            flash_cnt_ff <= flash_wrap ? '0 : flash_cnt_ff + 1'b1;
            flash_ff <= flash_wrap ? ~flash_ff : flash_ff;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            warn_lamp_ff <= 1'b0;
            shut_lamp_ff <= 1'b0;
            nonauto_ff <= 1'b0;
            stop_ff <= 1'b0;
            trip_ff <= 1'b0;
            standby_ff <= 1'b0;
        end else if (CE) begin
            warn_lamp_ff <= any_warn;  // [R1]
            shut_lamp_ff <= any_shut;  // [R2]
            nonauto_ff <= mode_off & flash_ff;  // [R6]
            stop_ff <= any_shut;  // [R4]
            trip_ff <= any_shut;  // [R4]
            standby_ff <= sreq_s & ~(any_shut | any_warn);  // [R12]
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            line1_ff <= "NO ACTIVE FAULT ";
            line2_ff <= "                ";
            code_ff <= 10'h000;
        end else if (CE) begin
            line1_ff <= nxt_line1;  // [R5]
            line2_ff <= nxt_line2;
            code_ff <= sel_code;
        end
    end

    // ------------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------------
    logic [N_EV-1:0] ev, istat_ff, nxt_istat, ien_ff, iclr;
    logic irq_ff;

    // new warning, new shutdown, something cleared
    assign ev = {|(ind_ff & ~nxt_ind), |(shut_act & ~ind_ff), |(warn_act & ~ind_ff)};
    // an event in the clear cycle survives
    assign nxt_istat = (istat_ff & ~iclr) | ev;

    // ------------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------------
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, aw_hold_ff, w_hold_ff, wstrb0_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff, wdata_ff, rd_mux;
    logic [7:0] awaddr_ff;
    logic aw_hs, w_hs, ar_hs, wr_go, wr_ok, rd_ok, wr_cust, wr_ien;

    assign aw_hs = AWVALID & awready_ff;
    assign w_hs = WVALID & wready_ff;
    assign ar_hs = ARVALID & arready_ff;
    assign wr_go = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    assign wr_ok = (awaddr_ff == ADDR_CUST) | (awaddr_ff == ADDR_ICLR) | (awaddr_ff == ADDR_IEN);
    assign wr_cust = wr_go & wstrb0_ff & (awaddr_ff == ADDR_CUST);
    assign wr_ien = wr_go & wstrb0_ff & (awaddr_ff == ADDR_IEN);
    assign iclr = (wr_go & wstrb0_ff & (awaddr_ff == ADDR_ICLR)) ? wdata_ff[N_EV-1:0] : '0;
    assign rd_ok = (ARADDR == ADDR_STATUS) | (ARADDR == ADDR_IND) | (ARADDR == ADDR_CUST) |
                   (ARADDR == ADDR_ISTAT) | (ARADDR == ADDR_ICLR) | (ARADDR == ADDR_IEN) |
                   (ARADDR == ADDR_DCODE);
    assign rd_mux = (ARADDR == ADDR_STATUS) ? {24'h00_0000, mode_s, standby_ff, trip_ff,
                                               nonauto_ff, shut_lamp_ff, warn_lamp_ff, irq_ff} :
                    (ARADDR == ADDR_IND) ? {3'h0, ind_ff} :
                    (ARADDR == ADDR_CUST) ? {28'h000_0000, cust_ff} :
                    (ARADDR == ADDR_ISTAT) ? {29'h0000_0000, istat_ff} :
                    (ARADDR == ADDR_IEN) ? {29'h0000_0000, ien_ff} :
                    (ARADDR == ADDR_DCODE) ? {22'h00_0000, code_ff} : 32'h0000_0000;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            istat_ff <= '0;
            ien_ff <= IEN_RST;
            cust_ff <= CUST_RST;
            irq_ff <= 1'b0;
        end else if (CE) begin
            istat_ff <= nxt_istat;
            ien_ff <= wr_ien ? wdata_ff[N_EV-1:0] : ien_ff;
            cust_ff <= wr_cust ? wdata_ff[N_CUST-1:0] : cust_ff;  // [R16]
            irq_ff <= |(nxt_istat & ien_ff);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (CE) begin
            if (aw_hs) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= AWADDR;
                awready_ff <= 1'b0;
            end
            if (w_hs) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= WDATA;
                wstrb0_ff <= WSTRB[0];
                wready_ff <= 1'b0;
            end
            if (wr_go) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_ff & BREADY) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= '0;
        end else if (CE) begin
            if (ar_hs) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
                rdata_ff <= rd_mux;
            end else if (rvalid_ff & RREADY) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // output drive
    // ------------------------------------------------------------------
    assign WARN_LAMP = warn_lamp_ff;
    assign SHUT_LAMP = shut_lamp_ff;
    assign NONAUTO_LAMP = nonauto_ff;
    assign ENGINE_STOP = stop_ff;
    assign BREAKER_TRIP = trip_ff;
    assign STANDBY = standby_ff;
    assign DISP_LINE1 = line1_ff;
    assign DISP_LINE2 = line2_ff;
    assign IRQ = irq_ff;
    assign AWREADY = awready_ff;
    assign WREADY = wready_ff;
    assign BVALID = bvalid_ff;
    assign BRESP = bresp_ff;
    assign ARREADY = arready_ff;
    assign RVALID = rvalid_ff;
    assign RRESP = rresp_ff;
    assign RDATA = rdata_ff;
endmodule

// ---- fanr_monitor.sv ----
// fanr_monitor: concurrent checks on the annunciator outputs
`timescale 1ns/1ps
module fanr_monitor
    import fanr_pkg::*;
#(
    parameter int FLASH_HALF = 8
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [N_COND_PIN-1:0] FAULT_COND,
    input wire logic IDLE_IN,
    input wire logic PANEL_RESET,
    input wire logic REMOTE_RESET,
    input wire logic [1:0] MODE_SEL,
    input wire logic WARN_LAMP,
    input wire logic SHUT_LAMP,
    input wire logic NONAUTO_LAMP,
    input wire logic ENGINE_STOP,
    input wire logic BREAKER_TRIP,
    input wire logic STANDBY
);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    // two spare cycles: counter reload plus output flop
    localparam int HALF_MAX = FLASH_HALF + 2;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    a_stop_trip_pair: assert property (ENGINE_STOP == SHUT_LAMP && BREAKER_TRIP == SHUT_LAMP)
        else $error("stop or trip differs from shutdown lamp");
    a_shut_stays_latched: assert property ((!PANEL_RESET && !REMOTE_RESET)[*8] ##0 SHUT_LAMP |=> SHUT_LAMP)
        else $error("shutdown lamp dropped without reset");
    a_warn_stays_latched: assert property ((!PANEL_RESET && !REMOTE_RESET && !IDLE_IN)[*8] ##0 WARN_LAMP |=> WARN_LAMP)
        else $error("warning lamp dropped without reset");
    a_red_on_shut: assert property ((|FAULT_COND[23:11])[*8] |-> SHUT_LAMP)
        else $error("shutdown condition without red lamp");
    a_standby_clean: assert property (STANDBY |-> !WARN_LAMP && !SHUT_LAMP)
        else $error("standby entered with fault unreset");
    a_nonauto_quiet: assert property ((MODE_SEL != FANR_MODE_OFF)[*8] |-> !NONAUTO_LAMP)
        else $error("non-automatic lamp lit outside off");
    a_nonauto_flash: assert property ($fell(NONAUTO_LAMP) && MODE_SEL == FANR_MODE_OFF
        |-> ##[1:HALF_MAX] (NONAUTO_LAMP || MODE_SEL != FANR_MODE_OFF))
        else $error("non-automatic lamp stopped flashing");
    a_press_clears_warn: assert property ((FAULT_COND == '0 && !IDLE_IN)[*8] ##0 $rose(PANEL_RESET)
        ##1 (FAULT_COND == '0 && !IDLE_IN)[*8] |-> !WARN_LAMP)
        else $error("panel press left warning lamp lit");
endmodule

// ---- fanr_panel.sv ----
// fanr_panel: front-panel reset switch and remote reset input model
`timescale 1ns/1ps
module fanr_panel (
    input wire logic clk,
    input wire logic go,
    input wire logic kind,
    output logic panel_sw,
    output logic remote_sw
);
    // ------------------------------------------------------------------
    // switch hold
    // ------------------------------------------------------------------
    // held long past the synchroniser so one press is one clean edge
    logic [3:0] hold_ff = 4'h0;
    always_ff @(posedge clk) begin
        if (go) begin
            hold_ff <= 4'hC;
        end else if (hold_ff != 4'h0) begin
            hold_ff <= hold_ff - 4'h1;
        end
    end
    assign panel_sw = !kind && hold_ff != 4'h0;
    assign remote_sw = kind && hold_ff != 4'h0;
endmodule

// ---- test_fault_annunciator_reset_logic.sv ----
// test_fault_annunciator_reset_logic: randomised fault, reset and register bench
`timescale 1ns/1ps
bind fanr_core fanr_monitor #(.FLASH_HALF(FLASH_HALF)) fanr_monitor_i (.*);
module test_fault_annunciator_reset_logic import fanr_pkg::*;;
    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    logic CLK_SYS = 0, RST_N = 0, IDLE_IN = 0, REMOTE_START = 0, AWVALID = 0, WVALID = 0, ARVALID = 0, go = 0, kind = 0;
    logic STANDBY_REQ = 1;
    logic [27:0] FAULT_COND = '0;
    logic [1:0] MODE_SEL = 2'h0, BRESP, RRESP, rresp;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0000_0000, RDATA, rdat;
    logic [127:0] DISP_LINE1, DISP_LINE2;
    logic PANEL_RESET, REMOTE_RESET, WARN_LAMP, SHUT_LAMP, NONAUTO_LAMP, ENGINE_STOP, BREAKER_TRIP, STANDBY, IRQ;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, nw;
    logic [28:0] ind, sm, clr;
    logic [3:0] cst;
    int bad_count = 0, check_count = 0, seed = 48, idx, md, st, k;
    always #2 CLK_SYS = ~CLK_SYS;
    fanr_panel fanr_panel_i (.clk(CLK_SYS), .go(go), .kind(kind), .panel_sw(PANEL_RESET), .remote_sw(REMOTE_RESET));
    // flash half period cut to 8 cycles to keep the run short
    fanr_core #(.FLASH_HALF(8)) fanr_core_i (.CE(1'b1), .WSTRB(4'hF), .BREADY(1'b1), .RREADY(1'b1), .*);
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic final_report;
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (!BVALID);
    endtask
    task automatic rd(input logic [7:0] a);
        ARADDR <= a;
        ARVALID <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            if (ARREADY) ARVALID <= 1'b0;
        end while (!RVALID);
        rdat = RDATA;
        rresp = RRESP;
    endtask
    task automatic settle;
        repeat (30) @(posedge CLK_SYS);
    endtask
    // shutdowns outrank warnings, lowest index wins within a class
    function automatic int dcode;
        int e;
        e = 0;
        for (int i = 28; i >= 0; i--) begin
            if (ind[i] && (sm[i] || e < 1000)) e = CODE_TAB[i] + (sm[i] ? 1000 : 0);
        end
        return e % 1000;
    endfunction
    task automatic chk;
        int e;
        e = dcode();
        cmp(32'({WARN_LAMP, SHUT_LAMP, ENGINE_STOP, BREAKER_TRIP, STANDBY}),
            32'({|(ind & ~sm), |(ind & sm), |(ind & sm), |(ind & sm), STANDBY_REQ && ind == '0}));
        rd(ADDR_IND);
        cmp(rdat, 32'(ind));
        rd(ADDR_DCODE);
        cmp(rdat, 32'(e));
        cmp(e != 0 ? DISP_LINE2[127:96] : DISP_LINE1[127:96],
            e != 0 ? {8'(48 + e / 100), 8'(48 + e / 10 % 10), 8'(48 + e % 10), 8'h20} : "NO A");
    endtask
    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        cst = 4'($random(seed));
        wr(ADDR_CUST, 32'(cst));
        rd(ADDR_CUST);
        cmp(rdat, 32'(cst));
        sm = SHUT_MASK | {cst, 25'h0};
        rd(8'h1C);
        cmp({rdat[29:0], rresp}, {30'h0, RESP_SLVERR});
        ind = '0;
        for (int it = 0; it < 40; it++) begin
            idx = $unsigned($random(seed)) % 29;
            md = $unsigned($random(seed)) % 3;
            st = $random(seed) & 1;
            STANDBY_REQ <= 1'($random(seed));
            wr(ADDR_IEN, it != 0 ? 32'h7 : 32'h0);
            wr(ADDR_ICLR, 32'h7);
            MODE_SEL <= 2'(md);
            REMOTE_START <= 1'(st);
            if (idx == 0) IDLE_IN <= 1'b1;
            else FAULT_COND[idx-1] <= 1'b1;
            settle;
            nw = !ind[idx] && (idx != 0 || md == 1);
            if (idx != 0 || md == 1) ind[idx] = 1'b1;
            chk;
            cmp(32'(IRQ), 32'(nw && it != 0));
            wr(ADDR_ICLR, 32'h7);
            FAULT_COND <= '0;
            IDLE_IN <= 1'b0;
            settle;
            if (idx == 0) ind[0] = 1'b0;
            chk;
            cmp(32'(IRQ), 32'(it != 0 && idx == 0 && md == 1));
            k = $random(seed) & 1;
            kind <= 1'(k);
            go <= 1'b1;
            @(posedge CLK_SYS);
            go <= 1'b0;
            settle;
            if (k != 0) clr = md == 2 ? ~sm | (st != 0 ? '0 : sm & ~ESTOP_BIT) : '0;
            else clr = ~sm | (md == 0 ? sm : '0);
            ind = ind & ~clr;
            chk;
        end
        final_report;
    end
    // run needs about 4500 cycles; this allows over twenty times that
    initial begin
        #400000;
        bad_count++;
        final_report;
    end
endmodule
